// [design/spt_consts.svh]
// constants for the suspend plane and throttle output block
// assumes inclusion by bare name from the package only; the design modules do not include it
`ifndef SPT_CONSTS_SVH
`define SPT_CONSTS_SVH

`define SPT_PIN_RESET      1'b0
`define SPT_PIN_IDLE       1'b1
`define SPT_ZZ_IDLE        1'b0
`define SPT_STOP_IDLE_N    1'b1
`define SPT_GPI_IDLE       1'b1
`define SPT_RATE_W         8
`define SPT_RATE_DEFAULT   8'h10
`define SPT_TICK_ONE       1

`endif

// [design/spt_pkg.sv]
// types shared by the suspend plane and throttle output block
// assumes spt_consts.svh is on the include path
`include "spt_consts.svh"

package spt_pkg;

  typedef enum logic [1:0] {
    SPT_WORKING,
    SPT_POWER_ON_SUSPEND,
    SPT_SUSPEND_TO_RAM,
    SPT_SUSPEND_TO_DISK
  } spt_sys_state_t;

  // suspend status and plane control pins, in pin order
  typedef struct packed {
    logic secondary_plane_ctl_n;
    logic tertiary_plane_ctl_n;
    logic host_clk_status_n;
    logic periph_suspend_status_n;
    logic cache_sram_powerdown;
  } spt_pins_t;

  // software values for the same pins used as general-purpose outputs
  typedef struct packed {
    logic gp_out_15;
    logic gp_out_16;
    logic gp_out_20;
    logic gp_out_21;
    logic gp_out_19;
  } spt_gpo_t;

  typedef struct packed {
    spt_pins_t pins;
    logic      cpu_stop_clock_req_n;
    logic      gp_in_8;
    logic      throttle_active;
  } spt_state_t;

endpackage

// [design/spt_rate_tick.sv]
// one-cycle enable pulse every period cycles while run is high
// assumes a single clock; period of zero behaves as one
`timescale 1ns/1ps

module spt_rate_tick #(
  parameter int W = `SPT_RATE_W
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  import spt_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } spt_tick_st_t;

  spt_tick_st_t st_reg;
  spt_tick_st_t st_next;
  logic [W-1:0] last;

  always_comb begin
    st_next = st_reg;
    last = (period == '0) ? '0 : period - W'(`SPT_TICK_ONE);
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= last) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + W'(`SPT_TICK_ONE);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_tick_needs_run: assert property (st_reg.tick |-> $past(run)) else $error("tick without run");
  a_tick_single: assert property (st_reg.tick && period > W'(`SPT_TICK_ONE) |=> !st_reg.tick)
    else $error("tick longer than one cycle");
endmodule

// [design/spt_suspend_outputs.sv]
// suspend plane controls, suspend status, cache power-down and thermal throttle
// assumes all inputs synchronous to clk_sys; no software registers, controls are ports
//
// Notes on behaviour
// - secondary plane control low during suspend-to-RAM and suspend-to-disk.
// - tertiary plane control low only during suspend-to-disk.
// - host clock status low on stop-clock or any suspend state.
// - peripheral suspend status low in any suspend state.
// - thermal detect active low; when enabled it forces clock throttling.
// - throttling toggles the stop-clock request at a programmable rate.
// - cache power-down high while the processor is in stop-clock.
// - unused thermal pin reads back as general-purpose input.
// - any unused status, plane or cache power-down pin becomes a software general-purpose output.
`timescale 1ns/1ps

module spt_suspend_outputs #(
  parameter int RATE_W = `SPT_RATE_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire spt_pkg::spt_sys_state_t sys_state,
  input  wire logic                  stop_clock_active,
  input  wire logic                  thermal_detect_n,
  input  wire logic                  thermal_enable,
  input  wire logic [RATE_W-1:0]     throttle_period,
  input  wire spt_pkg::spt_gpo_t     gpo_select,
  input  wire spt_pkg::spt_gpo_t     gpo_value,
  output spt_pkg::spt_pins_t         pins,
  output logic                       cpu_stop_clock_req_n,
  output logic                       gp_in_8,
  output logic                       throttle_active
);
  import spt_pkg::*;

  spt_state_t st_reg;
  spt_state_t st_next;
  logic       tick;
  logic       thermal_hit;
  logic       in_suspend;
  logic       in_ram_disk;
  logic       in_disk;
  logic       stopped;

  // throttle phase divider; restarts whenever throttling ends
  spt_rate_tick #(
    .W (RATE_W)
  ) u_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (st_reg.throttle_active),
    .period  (throttle_period),
    .tick    (tick)
  );

  always_comb begin
    st_next = st_reg;
    thermal_hit = thermal_enable && !thermal_detect_n;
    in_suspend  = 1'b0;
    in_ram_disk = 1'b0;
    in_disk     = 1'b0;
    // every code of the two-bit state is legal, so no default
    unique case (sys_state)
      SPT_WORKING: begin
        in_suspend = 1'b0;
      end
      SPT_POWER_ON_SUSPEND: begin
        in_suspend = 1'b1;
      end
      SPT_SUSPEND_TO_RAM: begin
        in_suspend  = 1'b1;
        in_ram_disk = 1'b1;
      end
      SPT_SUSPEND_TO_DISK: begin
        in_suspend  = 1'b1;
        in_ram_disk = 1'b1;
        in_disk     = 1'b1;
      end
    endcase

    st_next.throttle_active = thermal_hit;
    if (!thermal_hit) begin
      st_next.cpu_stop_clock_req_n = `SPT_STOP_IDLE_N;
    end else if (!st_reg.throttle_active) begin
      // first throttle phase stops the clock at once
      st_next.cpu_stop_clock_req_n = !`SPT_STOP_IDLE_N;
    end else if (tick) begin
      st_next.cpu_stop_clock_req_n = !st_reg.cpu_stop_clock_req_n;
    end

    // stop-clock from the clock logic or the throttle's own request
    stopped = stop_clock_active || !st_next.cpu_stop_clock_req_n;

    // each pin is registered from the state, so working releases it a cycle later
    st_next.pins.secondary_plane_ctl_n   = gpo_select.gp_out_15 ? gpo_value.gp_out_15 : !in_ram_disk;
    st_next.pins.tertiary_plane_ctl_n    = gpo_select.gp_out_16 ? gpo_value.gp_out_16 : !in_disk;
    st_next.pins.host_clk_status_n       = gpo_select.gp_out_20 ? gpo_value.gp_out_20
                                                                : !(stopped || in_suspend);
    st_next.pins.periph_suspend_status_n = gpo_select.gp_out_21 ? gpo_value.gp_out_21 : !in_suspend;
    st_next.pins.cache_sram_powerdown    = gpo_select.gp_out_19 ? gpo_value.gp_out_19 : stopped;

    // thermal pin is only software-visible when thermal detection is off
    st_next.gp_in_8 = thermal_enable ? `SPT_GPI_IDLE : thermal_detect_n;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.pins.secondary_plane_ctl_n   <= `SPT_PIN_RESET;
      st_reg.pins.tertiary_plane_ctl_n    <= `SPT_PIN_RESET;
      st_reg.pins.host_clk_status_n       <= `SPT_PIN_RESET;
      st_reg.pins.periph_suspend_status_n <= `SPT_PIN_RESET;
      st_reg.pins.cache_sram_powerdown    <= `SPT_ZZ_IDLE;
      st_reg.cpu_stop_clock_req_n         <= `SPT_STOP_IDLE_N;
      st_reg.gp_in_8                      <= `SPT_GPI_IDLE;
      st_reg.throttle_active              <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins                 = st_reg.pins;
  assign cpu_stop_clock_req_n = st_reg.cpu_stop_clock_req_n;
  assign gp_in_8              = st_reg.gp_in_8;
  assign throttle_active      = st_reg.throttle_active;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_secondary_plane_on: assert property (!gpo_select.gp_out_15 && (sys_state == SPT_SUSPEND_TO_RAM ||
    sys_state == SPT_SUSPEND_TO_DISK) |=> !pins.secondary_plane_ctl_n)
    else $error("secondary plane not asserted in deep suspend");
  a_tertiary_disk_only: assert property (!gpo_select.gp_out_16 |=>
    (pins.tertiary_plane_ctl_n == ($past(sys_state) != SPT_SUSPEND_TO_DISK)))
    else $error("tertiary plane wrong for state");
  a_host_status_stop: assert property (!gpo_select.gp_out_20 && stop_clock_active |=> !pins.host_clk_status_n)
    else $error("host status not asserted on stop clock");
  a_periph_suspend_set: assert property (!gpo_select.gp_out_21 |=>
    (pins.periph_suspend_status_n == ($past(sys_state) == SPT_WORKING)))
    else $error("peripheral status wrong for state");
  a_thermal_throttle_on: assert property (thermal_enable && !thermal_detect_n |=> throttle_active)
    else $error("thermal detect did not start throttling");
  a_no_throttle_stop: assert property (!thermal_enable |=> cpu_stop_clock_req_n && !throttle_active)
    else $error("stop clock request while throttling disabled");
  a_throttle_toggle: assert property (throttle_active && thermal_hit && tick |=>
    cpu_stop_clock_req_n != $past(cpu_stop_clock_req_n))
    else $error("stop clock request did not toggle on tick");
  a_zz_on_stop: assert property (!gpo_select.gp_out_19 && stop_clock_active |=> pins.cache_sram_powerdown)
    else $error("cache power-down missing in stop clock");
  a_thermal_gpi: assert property (!thermal_enable |=> gp_in_8 == $past(thermal_detect_n))
    else $error("thermal pin not readable as input");
  a_gpo_passthru: assert property (gpo_select.gp_out_21 |=> pins.periph_suspend_status_n == $past(gpo_value.gp_out_21))
    else $error("general-purpose output not driven");
  a_wake_release: assert property (!gpo_select.gp_out_15 && !gpo_select.gp_out_21 && sys_state == SPT_WORKING
    |=> pins.secondary_plane_ctl_n && pins.periph_suspend_status_n)
    else $error("suspend pins held after return to working");

  // plane controls in each of the four system states
  a_secondary_released: assert property (!gpo_select.gp_out_15 && (sys_state == SPT_WORKING ||
    sys_state == SPT_POWER_ON_SUSPEND) |=> pins.secondary_plane_ctl_n)
    else $error("secondary plane asserted outside deep suspend");
  a_disk_both_planes: assert property (!gpo_select.gp_out_15 && !gpo_select.gp_out_16 &&
    sys_state == SPT_SUSPEND_TO_DISK |=> !pins.secondary_plane_ctl_n && !pins.tertiary_plane_ctl_n)
    else $error("planes not both asserted in suspend-to-disk");
  a_pos_planes_high: assert property (!gpo_select.gp_out_15 && !gpo_select.gp_out_16 &&
    sys_state == SPT_POWER_ON_SUSPEND |=> pins.secondary_plane_ctl_n && pins.tertiary_plane_ctl_n)
    else $error("plane control asserted in power-on suspend");
  a_ram_tertiary_off: assert property (!gpo_select.gp_out_16 && sys_state == SPT_SUSPEND_TO_RAM
    |=> pins.tertiary_plane_ctl_n)
    else $error("tertiary plane asserted in suspend-to-ram");

  // host status covers every suspend state, and is free in working when nothing may stop the clock
  a_host_status_susp: assert property (!gpo_select.gp_out_20 && sys_state != SPT_WORKING
    |=> !pins.host_clk_status_n)
    else $error("host status not asserted in suspend");
  a_host_status_free: assert property (!gpo_select.gp_out_20 && sys_state == SPT_WORKING &&
    !stop_clock_active && !thermal_hit |=> pins.host_clk_status_n)
    else $error("host status asserted while clock runs");

  a_throttle_release: assert property (thermal_enable && thermal_detect_n
    |=> cpu_stop_clock_req_n && !throttle_active)
    else $error("throttling held after thermal detect released");
  // the first phase stops the clock at once, so a hot part is not left running while it waits for the first tick
  a_throttle_first: assert property (thermal_hit && !throttle_active |=> !cpu_stop_clock_req_n)
    else $error("first throttle phase did not stop the clock");
  a_throttle_hold: assert property (throttle_active && thermal_hit && !tick |=> $stable(cpu_stop_clock_req_n))
    else $error("stop clock request moved between ticks");

  // power-down is built from the next request and registered with it, so it never leads the processor into stop-clock
  a_zz_follows_req: assert property (!gpo_select.gp_out_19 |=>
    pins.cache_sram_powerdown == ($past(stop_clock_active) || !cpu_stop_clock_req_n))
    else $error("cache power-down does not track stop clock");
  a_zz_low_idle: assert property (!gpo_select.gp_out_19 && !stop_clock_active && !thermal_hit
    |=> !pins.cache_sram_powerdown)
    else $error("cache power-down while clock runs");

  a_gpi_forced: assert property (thermal_enable |=> gp_in_8)
    else $error("thermal pin visible while detection enabled");

  // every pin in general-purpose mode shows the software value a cycle later
  a_gpo_secondary: assert property (gpo_select.gp_out_15 |=> pins.secondary_plane_ctl_n == $past(gpo_value.gp_out_15))
    else $error("secondary pin not driven as output");
  a_gpo_tertiary: assert property (gpo_select.gp_out_16 |=> pins.tertiary_plane_ctl_n == $past(gpo_value.gp_out_16))
    else $error("tertiary pin not driven as output");
  a_gpo_host: assert property (gpo_select.gp_out_20 |=> pins.host_clk_status_n == $past(gpo_value.gp_out_20))
    else $error("host status pin not driven as output");
  a_gpo_zz: assert property (gpo_select.gp_out_19 |=> pins.cache_sram_powerdown == $past(gpo_value.gp_out_19))
    else $error("power-down pin not driven as output");

  a_wake_tertiary: assert property (!gpo_select.gp_out_16 && !gpo_select.gp_out_20 && sys_state == SPT_WORKING &&
    !stop_clock_active && !thermal_hit |=> pins.tertiary_plane_ctl_n && pins.host_clk_status_n)
    else $error("tertiary or host pin held after return to working");

  c_suspend_to_disk: cover property (sys_state == SPT_SUSPEND_TO_DISK ##1 !pins.tertiary_plane_ctl_n);
  c_throttle_cycle: cover property (throttle_active && !cpu_stop_clock_req_n ##[1:40] cpu_stop_clock_req_n);
  c_wake_up: cover property (!pins.periph_suspend_status_n ##1 pins.periph_suspend_status_n);
  c_gpi_read: cover property (!thermal_enable && !gp_in_8);
  c_pos_state: cover property (sys_state == SPT_POWER_ON_SUSPEND ##1 !pins.periph_suspend_status_n);
endmodule

// [verification/spt_far_sensor.sv]
// far-side thermal sensor driving the active-low thermal detect pin
// assumes the bench changes hot by non-blocking assignment at clk_sys rise
`timescale 1ns/1ps

module spt_far_sensor (
  input  wire logic clk_sys,
  input  wire logic hot,
  input  wire logic slow,
  output logic      thermal_detect_n
);
  logic hot_d = 1'b0;
  initial thermal_detect_n = 1'b1;
  // a slow sensor lags one cycle, like a filtered comparator
  always @(posedge clk_sys) begin
    hot_d <= hot;
    thermal_detect_n <= ~(slow ? hot_d : hot);
  end
endmodule

// [verification/suspend_plane_and_throttle_outputs_tb.sv]
// self-checking bench for spt_suspend_outputs with a cycle model
// assumes one 10 MHz clock and the registered one-cycle answer of the design
`timescale 1ns/1ps

module suspend_plane_and_throttle_outputs_tb;
  import spt_pkg::*;
  logic           clk_sys, sys_rst, stop_clock_active, thermal_enable, hot, slow;
  logic           thermal_detect_n, cpu_stop_clock_req_n, gp_in_8, throttle_active;
  logic [7:0]     throttle_period;
  spt_sys_state_t sys_state;
  spt_gpo_t       gpo_select, gpo_value;
  spt_pins_t      pins;
  int             fail_count, checks, seed, cyc, last_tog, p_eff;
  logic           prev_thr, prev_req, first;
  logic [7:0]     per_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h08};

  spt_suspend_outputs i_spt_suspend_outputs (.clk_sys(clk_sys), .sys_rst(sys_rst), .sys_state(sys_state),
    .stop_clock_active(stop_clock_active), .thermal_detect_n(thermal_detect_n), .thermal_enable(thermal_enable),
    .throttle_period(throttle_period), .gpo_select(gpo_select), .gpo_value(gpo_value), .pins(pins),
    .cpu_stop_clock_req_n(cpu_stop_clock_req_n), .gp_in_8(gp_in_8), .throttle_active(throttle_active));
  spt_far_sensor i_spt_far_sensor (.clk_sys(clk_sys), .hot(hot), .slow(slow), .thermal_detect_n(thermal_detect_n));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // inputs are read at the edge, before this edge's stimulus lands
  always @(posedge clk_sys) begin : model
    logic rs, thr, stopc, req_e, tdn, en;
    logic [4:0] fn, gs, gv;
    spt_sys_state_t st;
    rs = sys_rst;
    st = sys_state;
    en = thermal_enable;
    tdn = thermal_detect_n;
    thr = en & ~tdn;
    stopc = stop_clock_active;
    gs = gpo_select;
    gv = gpo_value;
    p_eff = (throttle_period == 8'h00) ? 1 : int'(throttle_period);
    cyc++;
    #1;
    if (rs || sys_rst) begin
      check(32'({pins, cpu_stop_clock_req_n, gp_in_8, throttle_active}), 32'h06, "reset");
      prev_thr = 1'b0;
    end else begin
      req_e = thr ? (prev_thr ? cpu_stop_clock_req_n : 1'b0) : 1'b1;
      if (thr && !prev_thr) begin
        first = 1'b1;
        last_tog = cyc;
      end else if (thr && cpu_stop_clock_req_n !== prev_req) begin
        if (!first) check(32'(cyc - last_tog), 32'(p_eff), "toggle gap");
        first = 1'b0;
        last_tog = cyc;
      end
      if (thr && cyc - last_tog > p_eff + 2) check(32'(cyc - last_tog), 32'(p_eff), "stuck request");
      stopc = stopc | ~req_e;
      fn = {!(st == SPT_SUSPEND_TO_RAM || st == SPT_SUSPEND_TO_DISK), st != SPT_SUSPEND_TO_DISK,
            !(st != SPT_WORKING || stopc), st == SPT_WORKING, stopc};
      check(32'({pins, cpu_stop_clock_req_n, gp_in_8, throttle_active}),
            32'({(gs & gv) | (~gs & fn), req_e, en ? 1'b1 : tdn, thr}), "outputs");
      prev_thr = thr;
    end
    prev_req = cpu_stop_clock_req_n;
  end

  task automatic rand_phase(input int n, input logic keep);
    repeat (n) begin
      @(posedge clk_sys);
      sys_state <= spt_sys_state_t'(2'($random(seed)));
      stop_clock_active <= 1'($random(seed));
      gpo_select <= spt_gpo_t'(5'($random(seed) & $random(seed)));
      gpo_value <= spt_gpo_t'(5'($random(seed)));
      if (!keep) begin
        thermal_enable <= 1'($random(seed));
        hot <= 1'($random(seed));
      end
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  initial begin
    {seed, sys_rst, stop_clock_active, thermal_enable, hot, slow} = {32'd77, 5'b10000};
    {sys_state, throttle_period, gpo_select, gpo_value} = {SPT_WORKING, 8'h03, 10'h000};
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rand_phase(200, 1'b0);
    // throttle at each rate, fast and slow sensor, period set before the alarm
    for (int i = 0; i < 5; i++) begin
      hot <= 1'b0;
      repeat (3) @(posedge clk_sys);
      // rate moves only after the slow sensor has let go, so no toggle gap spans two rates
      throttle_period <= per_tab[i];
      slow <= 1'(i);
      @(posedge clk_sys);
      hot <= 1'b1;
      thermal_enable <= 1'b1;
      rand_phase(40, 1'b1);
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rand_phase(20, 1'b1);
    hot <= 1'b0;
    repeat (3) @(posedge clk_sys);
    end_sim();
  end
endmodule
